// file: design/ctg_clamp_timing_generator.sv
`timescale 1ns/10ps
module ctg_clamp_timing_generator
   import ctg_pkg::*;
#(
   parameter int         CODE_W     = 8,
   parameter logic [6:0] SLAVE_ADDR = 7'h4c  // Arbitrary value
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset,
   input  wire logic                   i_hsync,
   input  wire logic [2:0][CODE_W-1:0] i_code,
   input  wire logic                   i_scl,
   input  wire logic                   i_sda,
   output logic                        o_sda_out,
   output logic                        o_sda_oe,
   output logic                        o_clamp,
   output logic      [2:0][CODE_W-1:0] o_offset
);

   ctg_cfg_type    cfg_r;
   ctg_wr_type     wr;
   ctg_tstate_type tstate_r;
   ctg_sstate_type sstate_r;
   logic [7:0]     cnt_r;
   logic           hsync_prev_r;
   logic           hs_trail;
   logic           scl_prev_r;
   logic           sda_prev_r;
   logic           scl_rise;
   logic           scl_fall;
   logic           bus_start;
   logic           bus_stop;
   logic [3:0]     bitcnt_r;
   logic [7:0]     shift_r;
   logic [7:0]     tx_r;
   logic [7:0]     sub_r;
   logic           rw_r;
   logic           nack_r;
   logic           oe_r;
   logic           wr_en_r;
   logic [7:0]     wr_addr_r;
   logic [7:0]     wr_data_r;
   logic [7:0]     rd_data;

   ////////////////////////////////////////////////////////////////////////
   // Clamp timing
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         hsync_prev_r <= 1'b0;
      end else begin
         hsync_prev_r <= i_hsync;
      end
   end

   assign hs_trail = hsync_prev_r & ~i_hsync;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tstate_r <= CTG_T_IDLE;
         cnt_r    <= 8'h00;
      end else if (hs_trail) begin
         cnt_r <= 8'h00;
         if (cfg_r.delay != 8'h00) begin
            tstate_r <= CTG_T_DELAY;
         end else if (cfg_r.length != 8'h00) begin
            tstate_r <= CTG_T_CLAMP;
         end else begin
            tstate_r <= CTG_T_IDLE;
         end
      end else begin
         unique case (tstate_r)
            CTG_T_IDLE: begin
               cnt_r <= 8'h00;
            end
            CTG_T_DELAY: begin
               if (cnt_r == cfg_r.delay - CTG_ONE8) begin
                  cnt_r    <= 8'h00;
                  tstate_r <= (cfg_r.length != 8'h00) ? CTG_T_CLAMP
                                                       : CTG_T_IDLE;
               end else begin
                  cnt_r <= cnt_r + CTG_ONE8;
               end
            end
            CTG_T_CLAMP: begin
               if (cnt_r == cfg_r.length - CTG_ONE8) begin
                  cnt_r    <= 8'h00;
                  tstate_r <= CTG_T_IDLE;
               end else begin
                  cnt_r <= cnt_r + CTG_ONE8;
               end
            end
            default: begin
               cnt_r    <= 8'h00;
               tstate_r <= CTG_T_IDLE;
            end
         endcase
      end
   end

   assign o_clamp = (tstate_r == CTG_T_CLAMP);

   ////////////////////////////////////////////////////////////////////////
   // Per-converter offset servos
   // one select bit per converter
   for (genvar ch = 0; ch < 3; ch++) begin : g_servo
      ctg_offset_servo #(
         .CODE_W     (CODE_W)
      ) u_servo (
         .i_clk      (i_clk),
         .i_reset    (i_reset),
         .i_clamp    (o_clamp),
         .i_midscale (cfg_r.midscale[ch]),
         .i_code     (i_code[ch]),
         .o_offset   (o_offset[ch])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   assign wr = '{en: wr_en_r, addr: wr_addr_r, data: wr_data_r};

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cfg_r.delay    <= CTG_DELAY_RST;
         cfg_r.length   <= CTG_LENGTH_RST;
         cfg_r.midscale <= CTG_SEL_RST;
      end else if (wr.en) begin
         if (wr.addr == CTG_REG_CLAMP_DELAY) begin
            cfg_r.delay <= wr.data;
         end
         if (wr.addr == CTG_REG_CLAMP_LENGTH) begin
            cfg_r.length <= wr.data;
         end
         if (wr.addr == CTG_REG_CLAMP_SELECT) begin
            cfg_r.midscale <= wr.data[CTG_SEL_MSB:CTG_SEL_LSB];
         end
      end
   end

   // Unmapped subaddresses read zero; bit 0 of select shows clamp active
   always_comb begin
      rd_data = 8'h00;
      if (sub_r == CTG_REG_CLAMP_DELAY) begin
         rd_data = cfg_r.delay;
      end else if (sub_r == CTG_REG_CLAMP_LENGTH) begin
         rd_data = cfg_r.length;
      end else if (sub_r == CTG_REG_CLAMP_SELECT) begin
         rd_data[CTG_SEL_MSB:CTG_SEL_LSB] = cfg_r.midscale;
         rd_data[CTG_STAT_BIT]            = o_clamp;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-wire serial slave
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_prev_r <= i_scl;
         sda_prev_r <= i_sda;
      end
   end

   assign scl_rise  = i_scl & ~scl_prev_r;
   assign scl_fall  = ~i_scl & scl_prev_r;
   assign bus_start = i_scl & scl_prev_r & sda_prev_r & ~i_sda;
   assign bus_stop  = i_scl & scl_prev_r & ~sda_prev_r & i_sda;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sstate_r  <= CTG_S_IDLE;
         bitcnt_r  <= 4'h0;
         shift_r   <= 8'h00;
         tx_r      <= 8'h00;
         sub_r     <= 8'h00;
         rw_r      <= 1'b0;
         nack_r    <= 1'b0;
         oe_r      <= 1'b0;
         wr_en_r   <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_en_r <= 1'b0;
         if (bus_start) begin
            sstate_r <= CTG_S_ADDR;
            bitcnt_r <= 4'h0;
            oe_r     <= 1'b0;
         end else if (bus_stop) begin
            sstate_r <= CTG_S_IDLE;
            oe_r     <= 1'b0;
         end else if (scl_rise) begin
            if (sstate_r == CTG_S_ADDR || sstate_r == CTG_S_SUB ||
                sstate_r == CTG_S_WDATA) begin
               shift_r  <= {shift_r[6:0], i_sda};
               bitcnt_r <= bitcnt_r + 4'h1;
            end else if (sstate_r == CTG_S_RACK) begin
               nack_r <= i_sda;
            end
         end else if (scl_fall) begin
            unique case (sstate_r)
               CTG_S_IDLE: begin
                  oe_r <= 1'b0;
               end
               CTG_S_ADDR: begin
                  if (bitcnt_r == CTG_BITS_BYTE) begin
                     if (shift_r[7:1] == SLAVE_ADDR) begin
                        rw_r     <= shift_r[0];
                        oe_r     <= 1'b1;
                        sstate_r <= CTG_S_ADDR_ACK;
                     end else begin
                        sstate_r <= CTG_S_IDLE;
                     end
                  end
               end
               CTG_S_ADDR_ACK: begin
                  bitcnt_r <= 4'h0;
                  if (rw_r) begin
                     tx_r     <= rd_data;
                     oe_r     <= ~rd_data[7];
                     sstate_r <= CTG_S_RDATA;
                  end else begin
                     oe_r     <= 1'b0;
                     sstate_r <= CTG_S_SUB;
                  end
               end
               CTG_S_SUB: begin
                  if (bitcnt_r == CTG_BITS_BYTE) begin
                     sub_r    <= shift_r;
                     oe_r     <= 1'b1;
                     sstate_r <= CTG_S_SUB_ACK;
                  end
               end
               CTG_S_WDATA: begin
                  if (bitcnt_r == CTG_BITS_BYTE) begin
                     wr_en_r   <= 1'b1;
                     wr_addr_r <= sub_r;
                     wr_data_r <= shift_r;
                     oe_r      <= 1'b1;
                     sstate_r  <= CTG_S_WACK;
                  end
               end
               CTG_S_SUB_ACK, CTG_S_WACK: begin
                  if (sstate_r == CTG_S_WACK) begin
                     sub_r <= sub_r + CTG_ONE8;
                  end
                  oe_r     <= 1'b0;
                  bitcnt_r <= 4'h0;
                  sstate_r <= CTG_S_WDATA;
               end
               CTG_S_RDATA: begin
                  if (bitcnt_r == CTG_BIT_LAST) begin
                     oe_r     <= 1'b0;
                     sub_r    <= sub_r + CTG_ONE8;
                     sstate_r <= CTG_S_RACK;
                  end else begin
                     tx_r     <= {tx_r[6:0], 1'b0};
                     oe_r     <= ~tx_r[6];
                     bitcnt_r <= bitcnt_r + 4'h1;
                  end
               end
               CTG_S_RACK: begin
                  bitcnt_r <= 4'h0;
                  if (nack_r) begin
                     oe_r     <= 1'b0;
                     sstate_r <= CTG_S_IDLE;
                  end else begin
                     tx_r     <= rd_data;
                     oe_r     <= ~rd_data[7];
                     sstate_r <= CTG_S_RDATA;
                  end
               end
               default: begin
                  oe_r     <= 1'b0;
                  sstate_r <= CTG_S_IDLE;
               end
            endcase
         end
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe  = oe_r;

endmodule : ctg_clamp_timing_generator

// file: pkg/ctg_pkg.sv
package ctg_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, serial subaddresses
   localparam logic [7:0] CTG_REG_CLAMP_DELAY  = 8'h19;
   localparam logic [7:0] CTG_REG_CLAMP_LENGTH = 8'h1a;
   localparam logic [7:0] CTG_REG_CLAMP_SELECT = 8'h1b;

   // Field layout of the clamp level select register
   localparam int         CTG_SEL_LSB          = 5;
   localparam int         CTG_SEL_MSB          = 7;
   localparam int         CTG_STAT_BIT         = 0;

   // Values after reset
   localparam logic [7:0] CTG_DELAY_RST        = 8'h08;
   localparam logic [7:0] CTG_LENGTH_RST       = 8'h14;
   localparam logic [2:0] CTG_SEL_RST          = 3'h0;
   localparam logic [7:0] CTG_OFS_RST          = 8'h80;

   // Clamp targets
   localparam logic [7:0] CTG_GROUND_CODE      = 8'h00;
   localparam logic [7:0] CTG_MID_CODE         = 8'h80;

   // Serial port counts
   localparam logic [3:0] CTG_BITS_BYTE        = 4'h8;
   localparam logic [3:0] CTG_BIT_LAST         = 4'h7;
   localparam logic [7:0] CTG_ONE8             = 8'h01;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      CTG_T_IDLE  = 2'b00,
      CTG_T_DELAY = 2'b01,
      CTG_T_CLAMP = 2'b10
   } ctg_tstate_type;

   typedef enum logic [3:0] {
      CTG_S_IDLE     = 4'b0000,
      CTG_S_ADDR     = 4'b0001,
      CTG_S_ADDR_ACK = 4'b0010,
      CTG_S_SUB      = 4'b0011,
      CTG_S_SUB_ACK  = 4'b0100,
      CTG_S_WDATA    = 4'b0101,
      CTG_S_WACK     = 4'b0110,
      CTG_S_RDATA    = 4'b0111,
      CTG_S_RACK     = 4'b1000
   } ctg_sstate_type;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } ctg_wr_type;

   typedef struct packed {
      logic [7:0] delay;
      logic [7:0] length;
      logic [2:0] midscale;
   } ctg_cfg_type;

endpackage : ctg_pkg

// file: design/ctg_offset_servo.sv
`timescale 1ns/10ps
module ctg_offset_servo
   import ctg_pkg::*;
#(
   parameter int CODE_W = 8
) (
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_clamp,
   input  wire logic              i_midscale,
   input  wire logic [CODE_W-1:0] i_code,
   output logic      [CODE_W-1:0] o_offset
);

   logic [CODE_W-1:0] offset_r;
   logic [CODE_W-1:0] target;

   assign target = i_midscale ? CODE_W'(CTG_MID_CODE)
                              : CODE_W'(CTG_GROUND_CODE);

   ////////////////////////////////////////////////////////////////////////
   // servo during clamp
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         offset_r <= CODE_W'(CTG_OFS_RST);
      end else if (i_clamp) begin
         if (i_code > target && offset_r != '0) begin
            offset_r <= offset_r - CODE_W'(1);
         end else if (i_code < target && offset_r != '1) begin
            offset_r <= offset_r + CODE_W'(1);
         end
      end
   end

   assign o_offset = offset_r;

endmodule : ctg_offset_servo

// file: verification/ctg_chk_sva.sv
`timescale 1ns/10ps
module ctg_chk
   import ctg_pkg::*;
#(
   parameter int CODE_W = 8
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_reset,
   input  wire logic                   i_hsync,
   input  wire logic [2:0][CODE_W-1:0] i_code,
   input  wire logic                   i_scl,
   input  wire logic                   i_sda,
   input  wire logic                   o_sda_out,
   input  wire logic                   o_sda_oe,
   input  wire logic                   o_clamp,
   input  wire logic [2:0][CODE_W-1:0] o_offset
);
   logic       armed_r;
   logic [8:0] run_r;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////
   // Clamp may only open after a sync trailing edge
   always_ff @(posedge i_clk) begin
      if (i_reset)
         armed_r <= 1'b0;
      else if ($past(i_hsync) && !i_hsync)
         armed_r <= 1'b1;
      else if (o_clamp)
         armed_r <= 1'b0;
   end
   // Length of one clamp run since the last trailing edge
   always_ff @(posedge i_clk) begin
      if (i_reset || !o_clamp || ($past(i_hsync) && !i_hsync))
         run_r <= 9'h000;
      else if (run_r != 9'h1ff)
         run_r <= run_r + 9'h001;
   end
   ////////////////////////////////////////////////////////////
   property p_offs_hold;
      $changed(o_offset) |-> $past(o_clamp);
   endproperty
   a_offs_hold: assert property (p_offs_hold)
      else $error("offset moved outside clamp");
   for (genvar c = 0; c < 3; c++) begin : g_ch
      property p_offs_step;
         $changed(o_offset[c]) |->
            (o_offset[c] == $past(o_offset[c]) + CODE_W'(1)
             && $past(i_code[c]) < CTG_MID_CODE)
            || (o_offset[c] == $past(o_offset[c]) - CODE_W'(1)
             && $past(i_code[c]) != '0);
      endproperty
      a_offs_step: assert property (p_offs_step)
         else $error("offset step wrong");
   end
   property p_offs_down;
      o_clamp && i_code[0] > CTG_MID_CODE && o_offset[0] != '0
         |=> o_offset[0] == $past(o_offset[0]) - CODE_W'(1);
   endproperty
   a_offs_down: assert property (p_offs_down)
      else $error("offset did not step down");
   property p_sda_zero;
      o_sda_out == 1'b0;
   endproperty
   a_sda_zero: assert property (p_sda_zero)
      else $error("open drain value not low");
   property p_oe_scl_low;
      $changed(o_sda_oe) |-> !i_scl && !$past(i_scl);
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data changed with clock high");
   property p_rst_vals;
      $fell(i_reset) |-> !o_clamp && !o_sda_oe
         && o_offset == {3{CTG_OFS_RST}};
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("reset values wrong");
   property p_clamp_cause;
      $rose(o_clamp) |-> armed_r;
   endproperty
   a_clamp_cause: assert property (p_clamp_cause)
      else $error("clamp without sync edge");
   property p_clamp_len;
      run_r <= 9'h100;
   endproperty
   a_clamp_len: assert property (p_clamp_len)
      else $error("clamp too long");
endmodule : ctg_chk

// file: verification/ctg_video_src.sv
`timescale 1ns/10ps
module ctg_video_src
   import ctg_pkg::*;
#(
   parameter int LINE = 200
) (
   input  wire logic            i_clk,
   input  wire logic [7:0]      i_width,
   input  wire logic [2:0][7:0] i_offset,
   output logic                 o_hsync,
   output logic      [2:0][7:0] o_code
);
   // Channel 0 starts above midscale; every level can reach code 0 and 128
   localparam logic [2:0][7:0] BLACK = {8'h70, 8'h40, 8'ha0};
   int pos = 0;
   initial o_hsync = 1'b0;
   always @(posedge i_clk) begin
      pos <= (pos == LINE - 1) ? 0 : pos + 1;
      o_hsync <= pos < int'(i_width);
   end
   // Black shifted two codes per offset step, offset 0x80 neutral
   always_comb begin
      for (int c = 0; c < 3; c++)
         o_code[c] = BLACK[c] + {i_offset[c][6:0], 1'b0};
   end
endmodule : ctg_video_src

// file: verification/ctg_clamp_timing_generator_tb.sv
`timescale 1ns/10ps
module ctg_clamp_timing_generator_tb
   import ctg_pkg::*;
;
   localparam logic [6:0] DEV = 7'h4c; // Arbitrary value
   localparam logic [7:0] D_TAB [5] = '{8'h08, 8'h26, 8'h00, 8'h03, 8'h02};
   localparam logic [7:0] L_TAB [5] = '{8'h14, 8'h14, 8'h05, 8'h00, 8'hff};
   logic            i_clk = 1'b0;
   logic            i_reset = 1'b1;
   logic            scl = 1'b1;
   logic            sda_drv = 1'b1;
   logic            hsync, oe, sda_out, clamp;
   logic            hs_q = 1'b0;
   logic            mon_on = 1'b0;
   logic [7:0]      width = 8'h10;
   logic [7:0]      dly = 8'h08;
   logic [7:0]      len = 8'h14;
   logic [9:0]      cnt = 10'h3ff;
   logic [2:0][7:0] code, offs;
   wire             sda;
   int              seed = 32'h0c6e;
   int              err_total = 0;
   int              checks_done = 0;
   assign sda = sda_drv & ~oe;
   initial forever #5 i_clk = ~i_clk;
   ctg_clamp_timing_generator #(.SLAVE_ADDR(DEV)) i_dut (
      .i_clk, .i_reset, .i_hsync(hsync), .i_code(code), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .o_clamp(clamp),
      .o_offset(offs));
   ctg_video_src i_src (.i_clk, .i_width(width), .i_offset(offs),
      .o_hsync(hsync), .o_code(code));
   ////////////////////////////////////////////////////////////
   // Clamp level seen at an edge, from cycles counted since trailing edge
   function automatic logic clamp_exp(input logic [9:0] n,
                                      input logic [7:0] d, l);
      return n >= 10'(d) && n < 10'(d) + 10'(l);
   endfunction : clamp_exp
   task automatic chk(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = sda;
      scl <= 1'b0;
      tick(2);
   endtask : bit_io
   task automatic start_cond;
      sda_drv <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(2);
      sda_drv <= 1'b0;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask : start_cond
   task automatic stop_cond;
      sda_drv <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(2);
      sda_drv <= 1'b1;
      tick(2);
   endtask : stop_cond
   task automatic xfer(input logic [7:0] d, input logic rd_b, exp_k,
                       output logic [7:0] q);
      logic k;
      for (int i = 7; i >= 0; i--)
         bit_io(rd_b | d[i], q[i]);
      bit_io(1'b1, k);
      if (!rd_b)
         chk(8'(k), 8'(exp_k));
   endtask : xfer
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      start_cond;
      xfer({DEV, 1'b0}, 1'b0, 1'b0, q);
      xfer(a, 1'b0, 1'b0, q);
      xfer(d, 1'b0, 1'b0, q);
      stop_cond;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      start_cond;
      xfer({DEV, 1'b0}, 1'b0, 1'b0, q);
      xfer(a, 1'b0, 1'b0, q);
      start_cond;
      xfer({DEV, 1'b1}, 1'b0, 1'b0, q);
      xfer(8'hff, 1'b1, 1'b0, q);
      stop_cond;
   endtask : rd
   ////////////////////////////////////////////////////////////
   // Clamp window expected from cycles since trailing edge
   always @(posedge i_clk) begin
      if (mon_on)
         chk(8'(clamp), 8'(clamp_exp(cnt, dly, len)));
      cnt <= (hs_q && !hsync) ? 10'h000 : cnt + 10'(cnt != 10'h3ff);
      hs_q <= hsync;
   end
   initial begin
      logic [7:0] q, nd, nl;
      logic [2:0] s;
      tick(8);
      i_reset <= 1'b0;
      tick(1);
      rd(CTG_REG_CLAMP_DELAY, q);
      chk(q, CTG_DELAY_RST);
      rd(CTG_REG_CLAMP_LENGTH, q);
      chk(q, CTG_LENGTH_RST);
      rd(CTG_REG_CLAMP_SELECT, q);
      chk(q & 8'hfe, 8'h00);
      rd(8'h30, q);
      chk(q, 8'h00);
      start_cond;
      xfer({~DEV, 1'b0}, 1'b0, 1'b1, q);
      stop_cond;
      for (int i = 0; i < 9; i++) begin
         mon_on <= 1'b0;
         width <= 8'h04 + 8'($random(seed) & 31);
         nd = (i < 5) ? D_TAB[i] : 8'($random(seed) & 63);
         nl = (i < 5) ? L_TAB[i] : 8'h20 + 8'($random(seed) & 63);
         s = 3'($random(seed));
         wr(CTG_REG_CLAMP_DELAY, nd);
         wr(CTG_REG_CLAMP_LENGTH, nl);
         wr(CTG_REG_CLAMP_SELECT, {s, 5'h1f});
         rd(CTG_REG_CLAMP_SELECT, q);
         chk(q & 8'hfe, {s, 5'h00});
         dly <= nd;
         len <= nl;
         tick(400);
         mon_on <= 1'b1;
         tick(800);
         if (nl >= 8'h20 && nl != 8'hff) begin
            for (int c = 0; c < 3; c++)
               chk(code[c], s[c] ? CTG_MID_CODE : CTG_GROUND_CODE);
         end
      end
      mon_on <= 1'b0;
      i_reset <= 1'b1;
      tick(8);
      i_reset <= 1'b0;
      tick(1);
      rd(CTG_REG_CLAMP_DELAY, q);
      chk(q, CTG_DELAY_RST);
      final_report();
   end
endmodule : ctg_clamp_timing_generator_tb
bind ctg_clamp_timing_generator ctg_chk #(.CODE_W(CODE_W)) i_chk (
   .i_clk, .i_reset, .i_hsync, .i_code, .i_scl, .i_sda,
   .o_sda_out, .o_sda_oe, .o_clamp, .o_offset);
